/* shared/ast_defines.svh */
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// register indexes on the plain register port
`define AST_OFS_SUM_LOW      5'h00
`define AST_OFS_SUM_HIGH     5'h01
`define AST_OFS_SUM_UPPER    5'h02
`define AST_OFS_SETPT_HIGH   5'h03
`define AST_OFS_SETPT_LOW    5'h04
`define AST_OFS_DEV_HIGH     5'h05
`define AST_OFS_DEV_LOW      5'h06
`define AST_OFS_LOWER_HIGH   5'h07
`define AST_OFS_LOWER_LOW    5'h08
`define AST_OFS_UPPER_HIGH   5'h09
`define AST_OFS_UPPER_LOW    5'h0a
`define AST_OFS_CTRL_THREE   5'h0b
`define AST_OFS_CONV_STATUS  5'h0c
`define AST_OFS_IRQ_STATUS   5'h0d
`define AST_OFS_IRQ_ENABLE   5'h0e
`define AST_OFS_IRQ_CLEAR    5'h0f

// field positions
`define AST_DEVIATION_FORMULA_SELECT_LSB         4
`define AST_TMD_LSB          0
`define AST_ABOVE_UPPER_BIT  6
`define AST_BELOW_LOWER_BIT  5
`define AST_IRQ_THRESH_BIT   0
`define AST_IRQ_DONE_BIT     1

// reset values
`define AST_RST_BYTE         8'h00
`define AST_RST_WORD         16'h0000
`define AST_RST_SUM          18'h00000
`define AST_RST_CTRL         6'h00

// sum field widths
`define AST_SUM_BITS         18
`define AST_SIGN_COPIES      6

`endif

/* shared/ast_pkg.sv */
`default_nettype none
package ast_pkg;

  // deviation formula select codes
  typedef enum logic [2:0] {
    AST_DEVIATION_FORMULA_SELECT_SAMPLE_PREV = 3'h0,
    AST_DEVIATION_FORMULA_SELECT_SAMPLE_SETPT = 3'h1,
    AST_DEVIATION_FORMULA_SELECT_SUM_SETPT = 3'h2,
    AST_DEVIATION_FORMULA_SELECT_SUM_PREV = 3'h3,
    AST_DEVIATION_FORMULA_SELECT_SAMPLE = 3'h4,
    AST_DEVIATION_FORMULA_SELECT_SUM = 3'h5,
    AST_DEVIATION_FORMULA_SELECT_PREV_SETPT = 3'h6,
    AST_DEVIATION_FORMULA_SELECT_SETPT_NEG = 3'h7
  } ast_deviation_formula_select_type;

  // threshold interrupt mode codes
  typedef enum logic [2:0] {
    AST_TMD_NEVER = 3'h0,
    AST_TMD_BELOW = 3'h1,
    AST_TMD_NOT_BELOW = 3'h2,
    AST_TMD_INSIDE = 3'h3,
    AST_TMD_OUTSIDE = 3'h4,
    AST_TMD_NOT_ABOVE = 3'h5,
    AST_TMD_ABOVE = 3'h6,
    AST_TMD_ALWAYS = 3'h7
  } ast_tmd_type;

endpackage
`default_nettype wire

/* logic/ast_irq_ctrl.sv */
`default_nettype none
module ast_irq_ctrl #(
  parameter int N = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] clear_in,
  input wire logic enable_wr_in,
  input wire logic [N-1:0] enable_data_in,
  output logic [N-1:0] status_out,
  output logic [N-1:0] enable_out,
  output logic irq_out
);

  // one sticky bit per event; a set in the clear cycle is kept
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          status_out[i] <= 1'b0;
        else
          status_out[i] <= event_in[i] | (status_out[i] & ~clear_in[i]);
      end
    end
  endgenerate

  // enable register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      enable_out <= '0;
    else if (enable_wr_in)
      enable_out <= enable_data_in;
  end

  // level output while any enabled bit is pending
  assign irq_out = |(status_out & enable_out);

endmodule
`default_nettype wire

/* logic/ast_dev_deviation_formula_select.sv */
`default_nettype none
`include "ast_defines.svh"
module ast_dev_deviation_formula_select (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [2:0] deviation_formula_select_in,
  input wire logic [2:0] tmd_in,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] prev_in,
  input wire logic [15:0] sum_in,
  input wire logic [15:0] setpoint_in,
  input wire logic [15:0] lower_in,
  input wire logic [15:0] upper_in,
  output logic [15:0] deviation_out,
  output logic above_upper_out,
  output logic below_lower_out,
  output logic thresh_event_out
);

  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [15:0] next_deviation;
  logic next_above;
  logic next_below;
  logic mode_hit;

  // operand choice; setpoint enters only for formulas that name it
  always_comb
  begin
    op_a = sample_in;
    op_b = 16'h0000;
    case (ast_pkg::ast_deviation_formula_select_type'(deviation_formula_select_in))
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SAMPLE_PREV: op_b = prev_in;
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SAMPLE_SETPT: op_b = setpoint_in;
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SUM_SETPT:
      begin
        op_a = sum_in;
        op_b = setpoint_in;
      end
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SUM_PREV:
      begin
        op_a = sum_in;
        op_b = prev_in;
      end
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SAMPLE: op_b = 16'h0000;
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SUM: op_a = sum_in;
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_PREV_SETPT:
      begin
        op_a = prev_in;
        op_b = setpoint_in;
      end
      ast_pkg::AST_DEVIATION_FORMULA_SELECT_SETPT_NEG:
      begin
        op_a = 16'h0000;
        op_b = setpoint_in;
      end
      default: op_b = 16'h0000;
    endcase
  end

  // difference wraps at 16 bits, as a signed register would
  assign next_deviation = op_a - op_b;

  // signed compares against both limits
  assign next_above = $signed(next_deviation) > $signed(upper_in);
  assign next_below = $signed(next_deviation) < $signed(lower_in);

  // interrupt permission by threshold mode
  always_comb
  begin
    case (ast_pkg::ast_tmd_type'(tmd_in))
      ast_pkg::AST_TMD_NEVER: mode_hit = 1'b0;
      ast_pkg::AST_TMD_BELOW: mode_hit = next_below;
      ast_pkg::AST_TMD_NOT_BELOW: mode_hit = ~next_below;
      ast_pkg::AST_TMD_INSIDE: mode_hit = ~next_below & ~next_above;
      ast_pkg::AST_TMD_OUTSIDE: mode_hit = next_below | next_above;
      ast_pkg::AST_TMD_NOT_ABOVE: mode_hit = ~next_above;
      ast_pkg::AST_TMD_ABOVE: mode_hit = next_above;
      ast_pkg::AST_TMD_ALWAYS: mode_hit = 1'b1;
      default: mode_hit = 1'b0;
    endcase
  end

  // results land together one cycle after start
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      deviation_out <= `AST_RST_WORD;
      above_upper_out <= 1'b0;
      below_lower_out <= 1'b0;
      thresh_event_out <= 1'b0;
    end
    else
    begin
      thresh_event_out <= start_in & mode_hit;
      if (start_in)
      begin
        deviation_out <= next_deviation;
        above_upper_out <= next_above;
        below_lower_out <= next_below;
      end
    end
  end

endmodule
`default_nettype wire

/* logic/ast_threshold_top.sv */
`default_nettype none
`include "ast_defines.svh"
module ast_threshold_top #(
  parameter int ADDR_W = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic conv_active_in,
  input wire logic conv_done_in,
  input wire logic [15:0] sample_in,
  output logic above_upper_out,
  output logic below_lower_out,
  output logic irq_out
);

  localparam int SB = `AST_SUM_BITS;

  // software-visible storage, then internal sample history and the calculation start strobe
  logic [SB-1:0] running_sum;
  logic [SB-1:0] next_running_sum;
  logic [15:0] setpoint;
  logic [15:0] lower_limit;
  logic [15:0] upper_limit;
  logic [2:0] deviation_formula_select;
  logic [2:0] threshold_interrupt_mode;
  logic [15:0] last_sample;
  logic [15:0] prev_sample;
  logic deviation_formula_select_start;

  // results from the calculation unit
  logic [15:0] deviation;
  logic above_upper_flag;
  logic below_lower_flag;
  logic thresh_event;

  // interrupt block signals
  logic [1:0] irq_events;
  logic [1:0] irq_clear;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;

  // address decode
  wire sel_sum_low = addr_in == `AST_OFS_SUM_LOW;
  wire sel_sum_high = addr_in == `AST_OFS_SUM_HIGH;
  wire sel_sum_upper = addr_in == `AST_OFS_SUM_UPPER;
  wire sel_setpt_high = addr_in == `AST_OFS_SETPT_HIGH;
  wire sel_setpt_low = addr_in == `AST_OFS_SETPT_LOW;
  wire sel_dev_high = addr_in == `AST_OFS_DEV_HIGH;
  wire sel_dev_low = addr_in == `AST_OFS_DEV_LOW;
  wire sel_lower_high = addr_in == `AST_OFS_LOWER_HIGH;
  wire sel_lower_low = addr_in == `AST_OFS_LOWER_LOW;
  wire sel_upper_high = addr_in == `AST_OFS_UPPER_HIGH;
  wire sel_upper_low = addr_in == `AST_OFS_UPPER_LOW;
  wire sel_ctrl = addr_in == `AST_OFS_CTRL_THREE;
  wire sel_status = addr_in == `AST_OFS_CONV_STATUS;
  wire sel_irq_status = addr_in == `AST_OFS_IRQ_STATUS;
  wire sel_irq_enable = addr_in == `AST_OFS_IRQ_ENABLE;
  wire sel_irq_clear = addr_in == `AST_OFS_IRQ_CLEAR;

  // sum writes are dropped silently during a conversion
  wire sum_wr_ok = wr_in & ~conv_active_in & ~conv_done_in;
  wire wr_sum_low = sum_wr_ok & sel_sum_low;
  wire wr_sum_high = sum_wr_ok & sel_sum_high;
  wire wr_sum_upper = sum_wr_ok & sel_sum_upper;

  // sign-extended sample for accumulation
  wire [SB-1:0] sample_wide = {{(SB - 16){sample_in[15]}}, sample_in};

  // six sign copies above the 18-bit value
  wire [23:0] running_sum_wide =
    {{`AST_SIGN_COPIES{running_sum[SB-1]}}, running_sum};

  // converter status byte: only the two limit flags live here
  wire [7:0] converter_status_register =
    (8'(above_upper_flag) << `AST_ABOVE_UPPER_BIT) |
    (8'(below_lower_flag) << `AST_BELOW_LOWER_BIT);

  wire [7:0] ctrl_byte =
    {1'b0, deviation_formula_select, 1'b0, threshold_interrupt_mode};

  // sum update: a finished conversion adds, software may load bytes
  always_comb
  begin
    next_running_sum = running_sum;
    if (conv_done_in)
      next_running_sum = SB'(running_sum + sample_wide);
    else if (wr_sum_low)
      next_running_sum = {running_sum[SB-1:8], wdata_in};
    else if (wr_sum_high)
      next_running_sum =
        {running_sum[SB-1:16], wdata_in, running_sum[7:0]};
    else if (wr_sum_upper)
      next_running_sum = {wdata_in[1:0], running_sum[15:0]};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      running_sum <= `AST_RST_SUM;
    else
      running_sum <= next_running_sum;
  end

  // setpoint bytes, cleared on reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      setpoint <= `AST_RST_WORD;
    else if (wr_in & sel_setpt_high)
      setpoint[15:8] <= wdata_in;
    else if (wr_in & sel_setpt_low)
      setpoint[7:0] <= wdata_in;
  end

  // lower limit bytes
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      lower_limit <= `AST_RST_WORD;
    else if (wr_in & sel_lower_high)
      lower_limit[15:8] <= wdata_in;
    else if (wr_in & sel_lower_low)
      lower_limit[7:0] <= wdata_in;
  end

  // upper limit bytes
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      upper_limit <= `AST_RST_WORD;
    else if (wr_in & sel_upper_high)
      upper_limit[15:8] <= wdata_in;
    else if (wr_in & sel_upper_low)
      upper_limit[7:0] <= wdata_in;
  end

  // formula and threshold mode selects
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      deviation_formula_select <= 3'h0;
      threshold_interrupt_mode <= 3'h0;
    end
    else if (wr_in & sel_ctrl)
    begin
      deviation_formula_select <= wdata_in[`AST_DEVIATION_FORMULA_SELECT_LSB +: 3];
      threshold_interrupt_mode <= wdata_in[`AST_TMD_LSB +: 3];
    end
  end

  // sample history; calculation runs the cycle after a conversion
  // so it sees the updated sum and the shifted previous sample
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      last_sample <= `AST_RST_WORD;
      prev_sample <= `AST_RST_WORD;
      deviation_formula_select_start <= 1'b0;
    end
    else
    begin
      deviation_formula_select_start <= conv_done_in;
      if (conv_done_in)
      begin
        prev_sample <= last_sample;
        last_sample <= sample_in;
      end
    end
  end

  // deviation, limit compare and mode-gated threshold event
  ast_dev_deviation_formula_select u_deviation_formula_select (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(deviation_formula_select_start),
    .deviation_formula_select_in(deviation_formula_select),
    .tmd_in(threshold_interrupt_mode),
    .sample_in(last_sample),
    .prev_in(prev_sample),
    .sum_in(running_sum[15:0]),
    .setpoint_in(setpoint),
    .lower_in(lower_limit),
    .upper_in(upper_limit),
    .deviation_out(deviation),
    .above_upper_out(above_upper_flag),
    .below_lower_out(below_lower_flag),
    .thresh_event_out(thresh_event)
  );

  // interrupt events and write-one-to-clear register
  assign irq_events = {deviation_formula_select_start, thresh_event};
  assign irq_clear = (wr_in & sel_irq_clear) ? wdata_in[1:0] : 2'b00;

  ast_irq_ctrl #(
    .N(2)
  ) u_irq (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .event_in(irq_events),
    .clear_in(irq_clear),
    .enable_wr_in(wr_in & sel_irq_enable),
    .enable_data_in(wdata_in[1:0]),
    .status_out(irq_status),
    .enable_out(irq_enable),
    .irq_out(irq_out)
  );

  // read selection; unmapped and write-only addresses read zero
  logic [7:0] read_value;
  always_comb
  begin
    read_value = 8'h00;
    if (sel_sum_low)
      read_value = running_sum_wide[7:0];
    else if (sel_sum_high)
      read_value = running_sum_wide[15:8];
    else if (sel_sum_upper)
      read_value = running_sum_wide[23:16];
    else if (sel_setpt_high)
      read_value = setpoint[15:8];
    else if (sel_setpt_low)
      read_value = setpoint[7:0];
    else if (sel_dev_high)
      read_value = deviation[15:8];
    else if (sel_dev_low)
      read_value = deviation[7:0];
    else if (sel_lower_high)
      read_value = lower_limit[15:8];
    else if (sel_lower_low)
      read_value = lower_limit[7:0];
    else if (sel_upper_high)
      read_value = upper_limit[15:8];
    else if (sel_upper_low)
      read_value = upper_limit[7:0];
    else if (sel_ctrl)
      read_value = ctrl_byte;
    else if (sel_status)
      read_value = converter_status_register;
    else if (sel_irq_status)
      read_value = {6'h00, irq_status};
    else if (sel_irq_enable)
      read_value = {6'h00, irq_enable};
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (rd_in)
      rdata_out <= read_value;
    else
      rdata_out <= 8'h00;
  end

  assign above_upper_out = above_upper_flag;
  assign below_lower_out = below_lower_flag;

endmodule
`default_nettype wire

/* bench/ast_threshold_properties.sv */
`default_nettype none
module ast_threshold_properties #(
  parameter int ADDR_W = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic conv_active_in,
  input wire logic conv_done_in,
  input wire logic [15:0] sample_in,
  input wire logic above_upper_out,
  input wire logic below_lower_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // read data must stand only in the cycle after a read strobe
  rd_idle_zero_a: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data seen outside read cycle");
  unmapped_zero_a: assert property (
    $past(rd_in) && $past(addr_in) > 5'h0f |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  sign_copy_a: assert property (
    $past(rd_in) && $past(addr_in) == 5'h02
    |-> rdata_out[7:2] == {6{rdata_out[1]}})
    else $error("sum sign copies wrong");
  // flags move only two edges after a conversion ends
  above_hold_a: assert property ($changed(above_upper_out)
    |-> $past(conv_done_in, 2)) else $error("above flag moved without result");
  below_hold_a: assert property ($changed(below_lower_out)
    |-> $past(conv_done_in, 2)) else $error("below flag moved without result");
  // status byte must agree with the flag pins unless a result just landed
  stat_match_a: assert property (
    $past(rd_in) && $past(addr_in) == 5'h0c
    && !$past(conv_done_in, 2) |-> rdata_out[6:5] ==
    {above_upper_out, below_lower_out}) else $error("status flags disagree");
  // irq rises from an enable write or a finished conversion
  irq_rise_a: assert property ($rose(irq_out) |-> $past(wr_in) ||
    $past(conv_done_in, 2) || $past(conv_done_in, 3))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("interrupt fell without a write");

  ast_conv_c: cover property (conv_done_in && !conv_active_in);
  ast_irq_c: cover property ($rose(irq_out));
  ast_above_c: cover property ($rose(above_upper_out) && sample_in[15]);
  ast_wr_c: cover property (wr_in && wdata_in == 8'h03);
endmodule
`default_nettype wire

/* bench/ast_threshold_tb_top.sv */
`default_nettype none
module ast_threshold_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic conv_active_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [7:0] rdata_out;
  logic above_upper_out, below_lower_out, irq_out;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [17:0] m_sum = 18'h00000;
  logic [15:0] m_last = 16'h0000, m_prev = 16'h0000;
  logic [15:0] m_sp, m_lo, m_up;
  logic [4:0] rw_regs [6] = '{5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0a};
  logic [15:0] lim_s [4] = '{16'hfeff, 16'hff00, 16'h0010, 16'h0011};

  always #50 clk_in = ~clk_in;

  ast_threshold_top u_ast_threshold_top (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .conv_active_in(conv_active_in),
    .conv_done_in(conv_done_in), .sample_in(sample_in),
    .above_upper_out(above_upper_out), .below_lower_out(below_lower_out),
    .irq_out(irq_out));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // each access leaves one idle cycle so a strobe is never set twice at once
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #10;
    chk($sformatf("reg %h", a), {8'h00, rdata_out}, {8'h00, exp});
    @(posedge clk_in);
  endtask

  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 5'h01, v[7:0]);
  endtask

  // waits past the threshold status edge, one edge after the result
  task automatic conv(input logic [15:0] s);
    sample_in <= s;
    conv_done_in <= 1'b1;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    m_sum = m_sum + {{2{s[15]}}, s};
    m_prev = m_last;
    m_last = s;
    repeat (3) @(posedge clk_in);
  endtask

  function automatic logic [15:0] dev_of(input logic [2:0] c);
    case (c)
      3'h0: return m_last - m_prev;
      3'h1: return m_last - m_sp;
      3'h2: return m_sum[15:0] - m_sp;
      3'h3: return m_sum[15:0] - m_prev;
      3'h4: return m_last;
      3'h5: return m_sum[15:0];
      3'h6: return m_prev - m_sp;
      default: return 16'h0000 - m_sp;
    endcase
  endfunction

  function automatic logic hit(input logic [2:0] m, input logic a, b);
    case (m)
      3'h0: return 1'b0;
      3'h1: return b;
      3'h2: return !b;
      3'h3: return !a && !b;
      3'h4: return a || b;
      3'h5: return !a;
      3'h6: return a;
      default: return 1'b1;
    endcase
  endfunction

  task automatic t_regs();
    foreach (rw_regs[i]) rdchk(rw_regs[i], 8'h00);
    foreach (rw_regs[i]) wr(rw_regs[i], {3'h5, rw_regs[i]});
    foreach (rw_regs[i]) rdchk(rw_regs[i], {3'h5, rw_regs[i]});
    wr(5'h05, 8'ha5);
    wr(5'h06, 8'ha5);
    wr(5'h1f, 8'ha5);
    rdchk(5'h05, 8'h00);
    rdchk(5'h06, 8'h00);
    rdchk(5'h1f, 8'h00);
    $display("register test done");
  endtask

  // sum wraps from -2 to +1, crossing the sign copies
  task automatic t_sum();
    wr(5'h00, 8'hfe);
    wr(5'h01, 8'hff);
    wr(5'h02, 8'h03);
    rdchk(5'h02, 8'hff);
    rdchk(5'h00, 8'hfe);
    conv_active_in <= 1'b1;
    wr(5'h00, 8'h12);
    rdchk(5'h00, 8'hfe);
    conv_active_in <= 1'b0;
    m_sum = 18'h3fffe;
    conv(16'h0003);
    rdchk(5'h00, 8'h01);
    rdchk(5'h01, 8'h00);
    rdchk(5'h02, 8'h00);
    $display("sum test done");
  endtask

  task automatic t_deviation_formula_select();
    logic [15:0] d;
    m_sp = 16'h0100;
    m_lo = 16'hff00;
    m_up = 16'h0010;
    wr16(5'h03, m_sp);
    wr16(5'h07, m_lo);
    wr16(5'h09, m_up);
    for (int c = 0; c < 8; c++)
    begin
      wr(5'h0b, {1'b0, 3'(c), 4'h7});
      conv(16'hfe80 + 16'(c) * 16'h0050);
      d = dev_of(3'(c));
      chk("above", above_upper_out, $signed(d) > $signed(m_up));
      chk("below", below_lower_out, $signed(d) < $signed(m_lo));
      rdchk(5'h05, d[15:8]);
      rdchk(5'h06, d[7:0]);
    end
    $display("formula test done");
  endtask

  // deviation equals the sample, stepped across both limits
  task automatic t_mode();
    logic e;
    wr(5'h0e, 8'h01);
    for (int m = 0; m < 8; m++)
      for (int i = 0; i < 4; i++)
      begin
        wr(5'h0b, {4'h4, 1'b0, 3'(m)});
        wr(5'h0f, 8'h03);
        conv(lim_s[i]);
        e = hit(3'(m), i == 3, i == 0);
        chk("irq", irq_out, e);
        rdchk(5'h0d, {6'h00, 1'b1, e});
      end
    wr(5'h0e, 8'h00);
    chk("masked irq", irq_out, 1'b0);
    wr(5'h0e, 8'h01);
    chk("unmasked irq", irq_out, 1'b1);
    wr(5'h0f, 8'h03);
    chk("cleared irq", irq_out, 1'b0);
    $display("interrupt mode test done");
  endtask

  // hang guard, far above the roughly 500 cycles the run needs
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_sum();
    t_deviation_formula_select();
    t_mode();
    give_verdict();
  end
endmodule

bind ast_threshold_top ast_threshold_properties #(.ADDR_W(ADDR_W))
  u_ast_threshold_properties (.clk_in(clk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .conv_active_in(conv_active_in),
  .conv_done_in(conv_done_in), .sample_in(sample_in),
  .above_upper_out(above_upper_out), .below_lower_out(below_lower_out),
  .irq_out(irq_out));
`default_nettype wire
